// ===== rtl/uis_pkg.sv
// Package: register map, field positions and reset values for the USB flag block
package uis_pkg;
    // Register indices; each register is one aligned word at four times its index
    localparam logic [15:0] ADDR_FLAGS1   = 16'hFF28;
    localparam logic [15:0] ADDR_STATUS2  = 16'hFF29;
    localparam logic [15:0] ADDR_CLEAR2   = 16'hFF2C;
    localparam logic [15:0] ADDR_EP1CFG   = 16'hFF30;
    localparam logic [15:0] ADDR_IRQMASK  = 16'hFF34;
    localparam logic [15:0] ADDR_SETUPBUF = 16'hFF40;
    localparam logic [15:0] ADDR_EP0TX    = 16'hFF48;
    localparam logic [15:0] ADDR_EP1FIFO  = 16'hFF4C;
    localparam logic [15:0] ADDR_EP0NAK   = 16'hFF50;
    // Bit positions
    localparam int BIT_DECODE  = 0;
    localparam int BIT_SETUP   = 1;
    localparam int BIT_STAGE   = 2;
    localparam int BIT_TXDONE  = 5;
    localparam int BIT_BI_TGL  = 4;
    localparam int BIT_BI_NAK  = 5;
    // Reset values
    localparam logic [7:0] RST_FLAGS1  = 8'h00;
    localparam logic [7:0] RST_STATUS2 = 8'h00;
    localparam logic [7:0] RST_MASK    = 8'hFF;
    localparam logic [7:0] RST_EP1CFG  = 8'h01;
    localparam logic [7:0] STATUS2_USED = 8'h30;
    // Setup packet length in bytes
    localparam int SETUP_BYTES = 8;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : uis_pkg

// ===== rtl/uis_flag.sv
// Sticky flag with set-over-clear priority
`timescale 1ns/1ps
module uis_flag (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic set,
    input  wire logic clr,
    output logic      q
);
    logic q_d;
    // Set wins so an event in the clearing cycle is kept
    assign q_d = set ? 1'b1 : (clr ? 1'b0 : q);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) q <= 1'b0;
        else q <= q_d;
    end
endmodule // uis_flag

// ===== rtl/uis_ctrl.sv
// USB endpoint-0 control flags and bulk-IN endpoint-1 status with AXI4-Lite access
//
// Overview of operation
// - Status stage entry sets stage flag, interrupt
// - Next SETUP token clears stage flag
// - Missed-ACK status entry also sets; on firmware read, buffer clear then clears NAK-write
// - Setup data stored sets setup-received flag
// - Repeated hardware-handled SETUP: no decode, setup set
// - Firmware-decoded request sets decode-pending flag
// - All setup bytes read clears decode-pending
// - Status-two register read-only, byte, reset zero
// - Any status-two change raises shared interrupt
// - Zero written to clear register clears bit
// - Unsupported endpoint bits treated invalid
// - Endpoint-1 IN answered NAK sets NAK flag
// - Endpoint-1 FIFO toggle sets toggled flag
// - First transmit-buffer write clears transmit-complete
`timescale 1ns/1ps
module uis_ctrl (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // USB engine events, one-cycle pulses on mclk; ev_fw_ctrl_read, iface_ep1_ok and setup_data are levels
    input  wire logic        ev_setup_token,
    input  wire logic        ev_setup_stored,
    input  wire logic        ev_setup_fw,
    input  wire logic        ev_status_stage,
    input  wire logic        ev_status_noack,
    input  wire logic        ev_fw_ctrl_read,
    input  wire logic        ev_ep0_tx_done,
    input  wire logic        ev_ep0_tx_cleared,
    input  wire logic        ev_ep1_in_nak,
    input  wire logic        ev_ep1_toggle,
    input  wire logic        ev_ep1_zlp,
    input  wire logic        iface_ep1_ok,
    input  wire logic [63:0] setup_data,
    // AXI4-Lite slave
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Outputs
    output logic             shared_usb_irq,
    output logic             ep0_nak_write_bit,
    output logic             ep1_fifo_wr
);
    logic rst_s1_q, rst_n;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // Write channel capture: address and data accepted in either order
    logic        aw_have_q, w_have_q;
    logic [15:0] aw_addr_q;
    logic [7:0]  w_byte_q;
    logic        w_lane0_q;
    wire         aw_take = s_axi_awvalid && s_axi_awready;
    wire         w_take  = s_axi_wvalid && s_axi_wready;
    wire         wr_go   = aw_have_q && w_have_q && !s_axi_bvalid;
    wire         rd_take = s_axi_arvalid && s_axi_arready;
    // Word index from the byte address; the lowest two bits select no register
    wire [15:0]  ar_addr = s_axi_araddr[17:2];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 16'h0000;
            w_byte_q      <= 8'h00;
            w_lane0_q     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr[17:2];
            end else if (wr_go) begin
                aw_have_q <= 1'b0;
            end
            if (w_take) begin
                w_have_q  <= 1'b1;
                w_byte_q  <= s_axi_wdata[7:0];
                w_lane0_q <= s_axi_wstrb[0];
            end else if (wr_go) begin
                w_have_q <= 1'b0;
            end
            s_axi_awready <= !aw_have_q && !aw_take && !wr_go;
            s_axi_wready  <= !w_have_q && !w_take && !wr_go;
        end
    end

    // Write decode; byte lane 0 carries the 8-bit registers
    wire wr_ok     = wr_go && w_lane0_q;
    wire wr_clear2 = wr_ok && (aw_addr_q == uis_pkg::ADDR_CLEAR2);
    wire wr_ep1cfg = wr_ok && (aw_addr_q == uis_pkg::ADDR_EP1CFG);
    wire wr_mask   = wr_ok && (aw_addr_q == uis_pkg::ADDR_IRQMASK);
    wire wr_ep0tx  = wr_ok && (aw_addr_q == uis_pkg::ADDR_EP0TX);
    wire wr_ep1ff  = wr_ok && (aw_addr_q == uis_pkg::ADDR_EP1FIFO);
    wire wr_flags1 = wr_ok && (aw_addr_q == uis_pkg::ADDR_FLAGS1);
    wire wr_ep0nak = wr_ok && (aw_addr_q == uis_pkg::ADDR_EP0NAK);
    // Status-two is read-only, so a write to it is refused like an unmapped one
    wire wr_known  = (aw_addr_q == uis_pkg::ADDR_CLEAR2)
                  || (aw_addr_q == uis_pkg::ADDR_EP1CFG)
                  || (aw_addr_q == uis_pkg::ADDR_IRQMASK)
                  || (aw_addr_q == uis_pkg::ADDR_EP0TX)
                  || (aw_addr_q == uis_pkg::ADDR_EP1FIFO)
                  || (aw_addr_q == uis_pkg::ADDR_FLAGS1)
                  || (aw_addr_q == uis_pkg::ADDR_EP0NAK);

    // Setup buffer byte reads; byte index from low address bits
    wire rd_setup = rd_take && (ar_addr[15:3] == uis_pkg::ADDR_SETUPBUF[15:3]);
    logic [7:0] setup_rd_seen_q;

    logic [7:0] ep1cfg_q, mask_q;
    logic       ep1_valid;
    assign ep1_valid = ep1cfg_q[0] && iface_ep1_ok;

    // Status-two flags: set-wins sticky bits, clear by writing zero
    logic [7:0] st2_set, st2_clr, st2_q;
    assign st2_set[uis_pkg::BIT_BI_NAK] = ev_ep1_in_nak && ep1_valid;
    assign st2_set[uis_pkg::BIT_BI_TGL] = (ev_ep1_toggle || ev_ep1_zlp) && ep1_valid;
    assign st2_clr[uis_pkg::BIT_BI_NAK] = wr_clear2 && !w_byte_q[uis_pkg::BIT_BI_NAK];
    assign st2_clr[uis_pkg::BIT_BI_TGL] = (wr_clear2 && !w_byte_q[uis_pkg::BIT_BI_TGL])
                                       || wr_ep1ff;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_st2
            if (uis_pkg::STATUS2_USED[gi]) begin : g_used
                uis_flag u_flag (
                    .clk   (mclk),
                    .rst_n (rst_n),
                    .set   (st2_set[gi]),
                    .clr   (st2_clr[gi]),
                    .q     (st2_q[gi])
                );
            end else begin : g_zero
                assign st2_set[gi] = 1'b0;
                assign st2_clr[gi] = 1'b0;
                assign st2_q[gi]   = 1'b0;
            end
        end
    endgenerate

    // Endpoint-0 flags
    logic stage_q, setup_q, decode_q, txdone_q;
    logic stage_d, setup_d, decode_d, txdone_d;
    wire  stage_set  = ev_status_stage || ev_status_noack;
    wire  setup_clr  = wr_flags1 && !w_byte_q[uis_pkg::BIT_SETUP];
    wire  all_read   = rd_setup && ((setup_rd_seen_q | (8'h01 << ar_addr[2:0])) == 8'hFF);
    // Hardware-handled repeat sets only the setup flag
    wire  decode_set = ev_setup_stored && ev_setup_fw;

    assign stage_d  = stage_set ? 1'b1 : (ev_setup_token ? 1'b0 : stage_q);
    assign setup_d  = ev_setup_stored ? 1'b1 : (setup_clr ? 1'b0 : setup_q);
    assign decode_d = decode_set ? 1'b1 : (all_read ? 1'b0 : decode_q);
    assign txdone_d = ev_ep0_tx_done ? 1'b1 : (wr_ep0tx ? 1'b0 : txdone_q);

    // NAK-write bit after missed ACK on firmware control read
    logic noack_pend_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            noack_pend_q      <= 1'b0;
            ep0_nak_write_bit <= 1'b0;
        end else begin
            if (ev_status_noack && ev_fw_ctrl_read) begin
                noack_pend_q <= 1'b1;
            end else if (ev_ep0_tx_cleared || ev_setup_token) begin
                noack_pend_q <= 1'b0;
            end
            // Hardware clear beats a firmware write in the same cycle
            if (noack_pend_q && ev_ep0_tx_cleared) begin
                ep0_nak_write_bit <= 1'b0;
            end else if (wr_ep0nak) begin
                ep0_nak_write_bit <= w_byte_q[0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stage_q  <= 1'b0;
            setup_q  <= 1'b0;
            decode_q <= 1'b0;
            txdone_q <= 1'b0;
        end else begin
            stage_q  <= stage_d;
            setup_q  <= setup_d;
            decode_q <= decode_d;
            txdone_q <= txdone_d;
        end
    end

    // Tracks which setup bytes have been read since the last store or the last complete read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            setup_rd_seen_q <= 8'h00;
        end else if (ev_setup_stored) begin
            // A fresh packet restarts the count even mid-read
            setup_rd_seen_q <= 8'h00;
        end else if (all_read) begin
            setup_rd_seen_q <= 8'h00;
        end else if (rd_setup) begin
            setup_rd_seen_q <= setup_rd_seen_q | (8'h01 << ar_addr[2:0]);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ep1cfg_q <= uis_pkg::RST_EP1CFG;
            mask_q   <= uis_pkg::RST_MASK;
        end else begin
            if (wr_ep1cfg) begin
                ep1cfg_q <= w_byte_q;
            end
            if (wr_mask) begin
                mask_q <= w_byte_q;
            end
        end
    end

    // Flag-one register view
    wire [7:0] flags1 = {2'b00, txdone_q, 2'b00, stage_q, setup_q, decode_q};

    // Shared interrupt: pulse on any status-two change, level while an unmasked flag stands
    logic [7:0] st2_prev_q;
    logic       chg_q;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st2_prev_q     <= uis_pkg::RST_STATUS2;
            chg_q          <= 1'b0;
            shared_usb_irq <= 1'b0;
            ep1_fifo_wr    <= 1'b0;
        end else begin
            st2_prev_q     <= st2_q;
            chg_q          <= (st2_q != st2_prev_q);
            shared_usb_irq <= |(st2_q & mask_q) || |(flags1 & mask_q) || chg_q;
            ep1_fifo_wr    <= wr_ep1ff;
        end
    end

    // Read mux
    logic [7:0] rd_byte;
    logic       rd_hit;
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        if (ar_addr == uis_pkg::ADDR_STATUS2) begin
            rd_byte = st2_q;
        end else if (ar_addr == uis_pkg::ADDR_FLAGS1) begin
            rd_byte = flags1;
        end else if (ar_addr == uis_pkg::ADDR_EP1CFG) begin
            rd_byte = ep1cfg_q;
        end else if (ar_addr == uis_pkg::ADDR_IRQMASK) begin
            rd_byte = mask_q;
        end else if (ar_addr == uis_pkg::ADDR_EP0NAK) begin
            rd_byte = {7'h00, ep0_nak_write_bit};
        end else if (ar_addr == uis_pkg::ADDR_CLEAR2) begin
            // Clear register holds nothing, so it reads as zero
            rd_byte = 8'h00;
        end else if (rd_setup) begin
            rd_byte = setup_data[{ar_addr[2:0], 3'b000} +: 8];
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= uis_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= uis_pkg::RESP_OKAY;
        end else begin
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? uis_pkg::RESP_OKAY : uis_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid && !rd_take && !s_axi_arready;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= rd_hit ? uis_pkg::RESP_OKAY : uis_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // uis_ctrl

// ===== testbench/uis_ctrl_sva.sv
// Port-level assertions for the USB flag block
`timescale 1ns/1ps
module uis_ctrl_chk (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        shared_usb_irq,
    input wire logic        ep1_fifo_wr
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
    rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    wr_lat_a: assert property (aw_w |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[17:2] == 16'h0000
        |=> s_axi_rresp == uis_pkg::RESP_SLVERR) else $error("unmapped read not refused");
    fifo_wr_a: assert property (aw_w && s_axi_awaddr[17:2] == uis_pkg::ADDR_EP1FIFO
        |-> ##[1:3] ep1_fifo_wr ##1 !ep1_fifo_wr) else $error("FIFO write strobe wrong");
    rst_quiet_a: assert property ($rose(rst_b) |-> !shared_usb_irq && !s_axi_bvalid)
        else $error("outputs active after reset");
endmodule // uis_ctrl_chk

bind uis_ctrl uis_ctrl_chk u_uis_ctrl_chk (.*);

// ===== testbench/uis_host_model.sv
// USB host side: token and transaction event pulses
`timescale 1ns/1ps
module uis_host_model (
    input  wire logic   mclk,
    output logic        ev_setup_token,
    output logic        ev_setup_stored,
    output logic        ev_setup_fw,
    output logic        ev_status_stage,
    output logic        ev_status_noack,
    output logic        ev_ep1_in_nak,
    output logic        ev_ep1_toggle,
    output logic        ev_ep1_zlp,
    output logic [63:0] setup_data
);
    logic [7:0] ev_q = 8'h00;
    assign {ev_setup_token, ev_setup_stored, ev_setup_fw, ev_status_stage,
            ev_status_noack, ev_ep1_in_nak, ev_ep1_toggle, ev_ep1_zlp} = ev_q;
    initial setup_data = 64'h0;
    // Mask order: token, stored, fw, status, noack, nak, toggle, zlp
    task pulse(input logic [7:0] m);
        @(posedge mclk);
        ev_q <= m;
        @(posedge mclk);
        ev_q <= 8'h00;
    endtask
    // Buffer content stays valid after storing, as the engine keeps it
    task setup(input logic fw, input logic [63:0] pkt);
        pulse(8'h80);
        setup_data <= pkt;
        pulse({2'b01, fw, 5'h00});
    endtask
endmodule // uis_host_model

// ===== testbench/usb_ctrl_bulkin_irq_status_bench.sv
// Self-checking bench for the USB flag block
`timescale 1ns/1ps
module usb_ctrl_bulkin_irq_status_bench;
    logic        mclk, rst_b, iface_ep1_ok, ev_fw_ctrl_read, ev_ep0_tx_done, ev_ep0_tx_cleared;
    logic        ev_setup_token, ev_setup_stored, ev_setup_fw, ev_status_stage, ev_status_noack;
    logic        ev_ep1_in_nak, ev_ep1_toggle, ev_ep1_zlp, shared_usb_irq, ep0_nak_write_bit;
    logic        ep1_fifo_wr, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [3:0]  s_axi_wstrb;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_q;
    logic [63:0] setup_data, pkt;
    int          err_count, n_checks, f1, s2;

    uis_ctrl u_uis_ctrl (.*);
    uis_host_model u_uis_host_model (.*);

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Ready is raised together with the request, so the slave's answer is taken in its first cycle
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        {s_axi_awaddr, s_axi_wdata} <= {14'h0, a, 2'b00, 24'h000000, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
    endtask
    task rd(input logic [15:0] a);
        @(posedge mclk);
        s_axi_araddr <= {14'h0, a, 2'b00};
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        rd_q = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask
    task rc(input logic [15:0] a, input logic [31:0] e);
        rd(a);
        chk(rd_q, e);
    endtask
    task ic(input logic e);
        repeat (3) @(posedge mclk);
        chk({31'h0, shared_usb_irq}, {31'h0, e});
    endtask
    task ep0p(input logic c);
        @(posedge mclk);
        {ev_ep0_tx_done, ev_ep0_tx_cleared} <= {!c, c};
        @(posedge mclk);
        {ev_ep0_tx_done, ev_ep0_tx_cleared} <= 2'b00;
    endtask
    task end_of_test();
        $display("Checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #1ms;
        err_count++;
        end_of_test();
    end

    initial begin
        {rst_b, ev_fw_ctrl_read, ev_ep0_tx_done, ev_ep0_tx_cleared, iface_ep1_ok} = 5'h01;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'hF;
        {err_count, n_checks, f1, s2} = 128'h0;
        void'($urandom(32'hE46A));
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (5) @(posedge mclk);
        rc(uis_pkg::ADDR_STATUS2, 32'h0);
        wr(uis_pkg::ADDR_STATUS2, 8'hFF);
        rc(uis_pkg::ADDR_STATUS2, 32'h0);
        wr(16'h0000, 8'h00);
        chk({30'h0, rsp}, {30'h0, uis_pkg::RESP_SLVERR});
        rd(16'h0000);
        pkt = {$urandom, $urandom};
        u_uis_host_model.setup(1'b1, pkt);
        f1 = 3;
        rc(uis_pkg::ADDR_FLAGS1, f1);
        ic(1'b1);
        for (int i = 0; i < 8; i++) begin
            rc(uis_pkg::ADDR_SETUPBUF + 16'(i), {24'h0, pkt[8*i +: 8]});
            if (i == 0) wr(uis_pkg::ADDR_FLAGS1, 8'h00);
            f1 = 1;
            if (i == 6) rc(uis_pkg::ADDR_FLAGS1, f1);
        end
        rc(uis_pkg::ADDR_FLAGS1, 32'h0);
        ic(1'b0);
        u_uis_host_model.pulse(8'h10);
        rc(uis_pkg::ADDR_FLAGS1, 32'h4);
        u_uis_host_model.setup(1'b0, pkt);
        rc(uis_pkg::ADDR_FLAGS1, 32'h2);
        wr(uis_pkg::ADDR_FLAGS1, 8'h00);
        ev_fw_ctrl_read <= 1'b1;
        wr(uis_pkg::ADDR_EP0NAK, 8'h01);
        u_uis_host_model.pulse(8'h08);
        rc(uis_pkg::ADDR_FLAGS1, 32'h4);
        rc(uis_pkg::ADDR_EP0NAK, 32'h1);
        ep0p(1'b1);
        repeat (3) @(posedge mclk);
        chk({31'h0, ep0_nak_write_bit}, 32'h0);
        ep0p(1'b0);
        rc(uis_pkg::ADDR_FLAGS1, 32'h24);
        wr(uis_pkg::ADDR_EP0TX, 8'h5A);
        rc(uis_pkg::ADDR_FLAGS1, 32'h4);
        u_uis_host_model.pulse(8'h04);
        s2 = 'h20;
        rc(uis_pkg::ADDR_STATUS2, s2);
        u_uis_host_model.pulse(8'h02);
        s2 = 'h30;
        rc(uis_pkg::ADDR_STATUS2, s2);
        wr(uis_pkg::ADDR_CLEAR2, 8'hDF);
        s2 = 'h10;
        rc(uis_pkg::ADDR_STATUS2, s2);
        wr(uis_pkg::ADDR_EP1FIFO, 8'hA5);
        rc(uis_pkg::ADDR_STATUS2, 32'h0);
        u_uis_host_model.pulse(8'h01);
        rc(uis_pkg::ADDR_STATUS2, s2);
        s_axi_wstrb <= 4'($urandom) & 4'hE;
        wr(uis_pkg::ADDR_IRQMASK, 8'h00);
        s_axi_wstrb <= 4'hF;
        chk({30'h0, rsp}, {30'h0, uis_pkg::RESP_OKAY});
        ic(1'b1);
        wr(uis_pkg::ADDR_IRQMASK, 8'h00);
        ic(1'b0);
        wr(uis_pkg::ADDR_IRQMASK, 8'hFF);
        ic(1'b1);
        wr(uis_pkg::ADDR_CLEAR2, 8'h00);
        iface_ep1_ok <= 1'b0;
        u_uis_host_model.pulse(8'h04);
        rc(uis_pkg::ADDR_STATUS2, 32'h0);
        iface_ep1_ok <= 1'b1;
        wr(uis_pkg::ADDR_EP1CFG, 8'h00);
        u_uis_host_model.pulse(8'h04);
        rc(uis_pkg::ADDR_STATUS2, 32'h0);
        end_of_test();
    end
endmodule // usb_ctrl_bulkin_irq_status_bench
